// file: dec_params.svh
// Opcode values, field positions and length constants for the decoder
`ifndef DEC_PARAMS_SVH
`define DEC_PARAMS_SVH
`define DEC_BUF_DEPTH 7
`define DEC_OP_ADD_RR 8'h88
`define DEC_OP_SUB_RR 8'h8a
`define DEC_OP_ADD_X 8'h78
`define DEC_OP_SUB_X 8'h7a
`define DEC_OP_PREFIX 8'h3c
`define DEC_OP_MULDIV 8'h05
`define DEC_OP_SPECIAL 8'h07
`define DEC_OP_EXT 8'h09
`define DEC_OP_INC_SD 8'h26
`define DEC_OP_DEC_SD 8'h27
`define DEC_OP_WIDE 8'h3e
`define DEC_OP_SIGN_EXT 8'h04
`define DEC_OP_SHIFT_R 8'h30
`define DEC_OP_SHIFT_L 8'h31
`define DEC_OP_BIT_SD 8'h08
`define DEC_OP_BIT_ACC 8'h03
`define DEC_OP_BIT_PSW 8'h02
`define DEC_OP_BIT_IND 8'h3d
`define DEC_B2_TRIPLE_MASK 8'h99
`define DEC_B2_IMM_MASK 8'h9f
`define DEC_B2_IMM_VAL 8'h9b
`define DEC_B2_PTR_SB 8'hf8
`define DEC_B2_PTR_SA 8'hf9
`define DEC_B2_FIX_ADD 8'hfe
`define DEC_B2_FIX_SUB 8'hff
`define DEC_B2_MAC 8'h85
`define DEC_B2_MAC_SAT 8'h95
`define DEC_B2_INCREMENT_WORD_SD 8'he8
`define DEC_B2_DECREMENT_WORD_SD 8'he9
`define DEC_B2_SAC1 8'h64
`define DEC_B2_SAC2 8'h41
`define DEC_B2_SAC3 8'h46
`define DEC_B2_ABS 8'hd0
`define DEC_NIB_MUL_UB 4'h0
`define DEC_NIB_DIV_UW 4'h1
`define DEC_NIB_MUL_UW 4'h2
`define DEC_NIB_MUL_SW 4'h3
`define DEC_NIB_DIV_UX 4'he
`define DEC_NIB_NROR 4'h8
`define DEC_NIB_NROL 4'h9
`define DEC_NIB_INCDEC 4'hc
`define DEC_NIB_PAIR 4'h4
`define DEC_NIB_WINC 4'hd
`define DEC_NIB_WDEC 4'hf
`define DEC_BITOP_MAX 4'h3
`define DEC_F_HI 7:4
`define DEC_F_LO 3:0
`define DEC_F_REG 2:0
`define DEC_F_CNT 5:3
`define DEC_F_VAR 7:6
`define DEC_F_GA 6:5
`define DEC_F_GB 2:1
`define DEC_F_PP 1:0
`define DEC_B_SEL 3
`define DEC_B_DIR 0
`define DEC_B_HIPAIR 2
`define DEC_B_TOP 7
`define DEC_B_TRI 4
`define DEC_VAR_ROTC 2'h0
`define DEC_VAR_ROT 2'h1
`define DEC_VAR_SHIFT 2'h2
`define DEC_VAR_SHIFTW 2'h3
`define DEC_LEN1 3'h1
`define DEC_LEN2 3'h2
`define DEC_LEN3 3'h3
`define DEC_LEN4 3'h4
`define DEC_LEN5 3'h5
`define DEC_LEN6 3'h6
`endif

// file: dec_pkg.sv
// Types shared by the decoder modules
package dec_pkg;
  typedef enum logic [1:0] {ST_FILL = 2'h1, ST_DONE = 2'h2} dec_state_e;
  typedef enum logic [4:0] {
    CL_NONE, CL_ADD_TRIPLE, CL_SUB_TRIPLE, CL_MUL_UB, CL_MUL_UW, CL_MUL_SW,
    CL_DIV_UW, CL_DIV_UX, CL_MAC, CL_MAC_SAT, CL_SUM_ABS, CL_INC, CL_DEC,
    CL_INC_WORD, CL_DEC_WORD, CL_INC_TRIPLE, CL_DEC_TRIPLE, CL_FIX_ADD,
    CL_FIX_SUB, CL_SIGN_EXT, CL_ROT, CL_ROT_CARRY, CL_SHIFT, CL_SHIFT_WORD,
    CL_NIB_ROR, CL_NIB_ROL, CL_BIT
  } dec_class_e;
  typedef enum logic [2:0] {
    SP_NONE, SP_SHORT_B, SP_SHORT_A, SP_ACC, SP_PSW, SP_IND, SP_ABS
  } dec_space_e;
endpackage

// file: dec_if.sv
// Carrier between the byte collector and the decoding core
`include "dec_params.svh"
interface dec_if #(parameter int DEPTH = `DEC_BUF_DEPTH);
  logic [7:0] data;
  logic take;
  logic clr;
  logic [2:0] cnt;
  logic [7:0] view [DEPTH];
  modport collect (input data, input take, input clr, output cnt,
    output view);
  modport core (output data, output take, output clr, input cnt,
    input view);
endinterface

// file: dec_collect.sv
// Byte collector: holds the bytes of the instruction being assembled
`include "dec_params.svh"
module dec_collect import dec_pkg::*; #(
  parameter int DEPTH = `DEC_BUF_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  dec_if.collect bus
);
  logic [7:0] buf_r [DEPTH];
  logic [2:0] cnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // Fill count; a clear wins over a take so the next opcode starts at zero
  always_ff @(posedge clk) begin
    if (sys_rst || bus.clr) begin
      cnt_r <= 3'h0;
    end else if (bus.take) begin
      cnt_r <= cnt_r + 3'h1;
    end
  end

  assign bus.cnt = cnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // One storage byte per slot; the slot at the fill count shows the byte
  // arriving now, so the core sees a complete opcode without a stall cycle
  for (genvar i = 0; i < DEPTH; i++) begin : g_slot
    always_ff @(posedge clk) begin
      if (sys_rst || bus.clr) begin
        buf_r[i] <= 8'h00;
      end else if (bus.take && cnt_r == 3'(i)) begin
        buf_r[i] <= bus.data;
      end
    end
    assign bus.view[i] = (cnt_r == 3'(i)) ? bus.data : buf_r[i];
  end
endmodule

// file: dec_top.sv
// Opcode decoder for arithmetic, shift, rotate and bit-manipulation forms
`include "dec_params.svh"
module dec_top import dec_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output logic byte_ready,
  output logic dec_done,
  output logic dec_undef,
  output dec_class_e dec_class,
  output logic [2:0] dec_len,
  output logic dec_dir,
  output logic [2:0] dec_reg_a,
  output logic [2:0] dec_reg_b,
  output logic [2:0] dec_count,
  output logic [2:0] dec_bit_num,
  output logic [3:0] dec_bit_op,
  output logic dec_member,
  output dec_space_e dec_space,
  output logic [7:0] dec_offset,
  output logic [23:0] dec_imm
);
  dec_if bus ();
  dec_state_e state_r, state_nxt;
  logic [7:0] s [6];
  logic [7:0] ob;
  logic pre, pre_ok, bok, undef, complete;
  logic [2:0] hdr, len, n;
  dec_class_e cls;
  dec_space_e space;
  logic dir, member;
  logic [2:0] reg_a, reg_b, cnt_f, bit_num;
  logic [3:0] bit_op;
  logic [7:0] off;
  logic [23:0] imm;

  dec_collect u_collect (.clk(clk), .sys_rst(sys_rst), .bus(bus.collect));

  ////////////////////////////////////////////////////////////////////////////
  // Bytes are taken only while ready; the fetch stage holds otherwise
  assign bus.data = byte_data;
  assign bus.take = byte_valid && byte_ready;
  assign bus.clr = complete;
  assign n = bus.cnt + 3'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the bytes seen so far, including the one arriving now
  always_comb begin
    pre = (bus.view[0] == `DEC_OP_PREFIX);
    for (int i = 0; i < 6; i++) begin
      s[i] = pre ? bus.view[i + 1] : bus.view[i];
    end
    ob = (s[0] == `DEC_OP_EXT) ? s[2] : s[1];
    bok = (ob[`DEC_F_HI] <= `DEC_BITOP_MAX);
    cls = CL_NONE;
    undef = 1'b1;
    pre_ok = 1'b0;
    hdr = `DEC_LEN1;
    len = `DEC_LEN1;
    dir = 1'b0;
    reg_a = 3'h0;
    reg_b = 3'h0;
    cnt_f = 3'h0;
    bit_num = ob[`DEC_F_REG];
    bit_op = ob[`DEC_F_HI];
    member = ob[`DEC_B_SEL];
    space = SP_NONE;
    off = 8'h00;
    imm = 24'h000000;
    case (s[0])
      `DEC_OP_ADD_RR, `DEC_OP_SUB_RR: begin
        hdr = `DEC_LEN2;
        len = `DEC_LEN2;
        cls = s[0][1] ? CL_SUB_TRIPLE : CL_ADD_TRIPLE;
        undef = (s[1] & `DEC_B2_TRIPLE_MASK) != `DEC_B2_TRIPLE_MASK;
        reg_a = {1'b0, s[1][`DEC_F_GA]};
        reg_b = {1'b0, s[1][`DEC_F_GB]};
      end
      `DEC_OP_ADD_X, `DEC_OP_SUB_X: begin
        hdr = `DEC_LEN2;
        len = `DEC_LEN3;
        cls = s[0][1] ? CL_SUB_TRIPLE : CL_ADD_TRIPLE;
        off = s[2];
        if ((s[1] & `DEC_B2_IMM_MASK) == `DEC_B2_IMM_VAL) begin
          len = `DEC_LEN5;
          undef = 1'b0;
          reg_a = {1'b0, s[1][`DEC_F_GA]};
          imm = {s[4], s[3], s[2]};
        end else if (s[1] == `DEC_B2_PTR_SB || s[1] == `DEC_B2_PTR_SA) begin
          undef = 1'b0;
          space = s[1][`DEC_B_DIR] ? SP_SHORT_A : SP_SHORT_B;
        end
      end
      `DEC_OP_MULDIV: begin
        hdr = `DEC_LEN2;
        len = `DEC_LEN2;
        reg_a = s[1][`DEC_F_REG];
        undef = !s[1][`DEC_B_SEL];
        case (s[1][`DEC_F_HI])
          `DEC_NIB_MUL_UB: begin cls = CL_MUL_UB; pre_ok = 1'b1; end
          `DEC_NIB_DIV_UW: begin cls = CL_DIV_UW; pre_ok = 1'b1; end
          `DEC_NIB_MUL_UW: cls = CL_MUL_UW;
          `DEC_NIB_MUL_SW: cls = CL_MUL_SW;
          `DEC_NIB_DIV_UX: cls = CL_DIV_UX;
          `DEC_NIB_NROR: cls = CL_NIB_ROR;
          `DEC_NIB_NROL: cls = CL_NIB_ROL;
          default: undef = 1'b1;
        endcase
        if (s[1] == `DEC_B2_FIX_ADD || s[1] == `DEC_B2_FIX_SUB) begin
          undef = 1'b0;
          cls = s[1][`DEC_B_DIR] ? CL_FIX_SUB : CL_FIX_ADD;
        end
      end
      `DEC_OP_SPECIAL: begin
        hdr = `DEC_LEN2;
        len = `DEC_LEN3;
        if (s[1] == `DEC_B2_MAC || s[1] == `DEC_B2_MAC_SAT) begin
          undef = 1'b0;
          cls = (s[1] == `DEC_B2_MAC) ? CL_MAC : CL_MAC_SAT;
          imm = {16'h0000, s[2]};
        end else if (s[1] == `DEC_B2_INCREMENT_WORD_SD || s[1] == `DEC_B2_DECREMENT_WORD_SD) begin
          undef = 1'b0;
          pre_ok = 1'b1;
          cls = s[1][`DEC_B_DIR] ? CL_DEC_WORD : CL_INC_WORD;
          space = SP_SHORT_B;
          off = s[2];
        end
      end
      `DEC_OP_EXT: begin
        hdr = (s[1] == `DEC_B2_SAC1) ? `DEC_LEN4 : `DEC_LEN3;
        len = `DEC_LEN4;
        if (s[1] == `DEC_B2_SAC1) begin
          undef = !(s[2] == `DEC_B2_SAC2 && s[3] == `DEC_B2_SAC3);
          cls = CL_SUM_ABS;
        end else if (s[1] == `DEC_B2_ABS) begin
          undef = !bok;
          cls = CL_BIT;
          space = SP_ABS;
          // Upper address byte travels first in the 24-bit form
          len = member ? `DEC_LEN6 : `DEC_LEN5;
          imm = member ? {s[3], s[5], s[4]} : {8'h00, s[4], s[3]};
        end
      end
      `DEC_OP_INC_SD, `DEC_OP_DEC_SD: begin
        len = `DEC_LEN2;
        undef = 1'b0;
        pre_ok = 1'b1;
        cls = s[0][`DEC_B_DIR] ? CL_DEC : CL_INC;
        space = SP_SHORT_B;
        off = s[1];
      end
      `DEC_OP_WIDE: begin
        hdr = `DEC_LEN2;
        len = `DEC_LEN2;
        reg_a = {1'b0, s[1][`DEC_F_GA]};
        if (s[1][`DEC_F_LO] == `DEC_NIB_WINC ||
            s[1][`DEC_F_LO] == `DEC_NIB_WDEC) begin
          if (!s[1][`DEC_B_TOP] && !s[1][`DEC_B_TRI]) begin
            undef = 1'b0;
            cls = s[1][1] ? CL_DEC_WORD : CL_INC_WORD;
          end else if (s[1][`DEC_B_TOP] && s[1][`DEC_B_TRI]) begin
            undef = 1'b0;
            cls = s[1][1] ? CL_DEC_TRIPLE : CL_INC_TRIPLE;
          end
        end
      end
      `DEC_OP_SIGN_EXT: begin
        undef = 1'b0;
        cls = CL_SIGN_EXT;
      end
      `DEC_OP_SHIFT_R, `DEC_OP_SHIFT_L: begin
        hdr = `DEC_LEN2;
        len = `DEC_LEN2;
        undef = 1'b0;
        dir = s[0][`DEC_B_DIR];
        cnt_f = s[1][`DEC_F_CNT];
        reg_a = s[1][`DEC_F_REG];
        pre_ok = 1'b1;
        case (s[1][`DEC_F_VAR])
          `DEC_VAR_ROTC: cls = CL_ROT_CARRY;
          `DEC_VAR_ROT: cls = CL_ROT;
          `DEC_VAR_SHIFT: cls = CL_SHIFT;
          default: begin cls = CL_SHIFT_WORD; pre_ok = 1'b0; end
        endcase
      end
      `DEC_OP_BIT_SD, `DEC_OP_BIT_ACC, `DEC_OP_BIT_PSW, `DEC_OP_BIT_IND: begin
        hdr = `DEC_LEN2;
        len = `DEC_LEN2;
        undef = !bok;
        cls = CL_BIT;
        pre_ok = (s[0] == `DEC_OP_BIT_SD);
        case (s[0])
          `DEC_OP_BIT_SD: begin
            len = `DEC_LEN3;
            space = SP_SHORT_B;
            off = s[2];
          end
          `DEC_OP_BIT_ACC: space = SP_ACC;
          `DEC_OP_BIT_PSW: space = SP_PSW;
          default: space = SP_IND;
        endcase
      end
      default: begin
        reg_a = s[0][`DEC_F_REG];
        if (s[0][`DEC_F_HI] == `DEC_NIB_INCDEC) begin
          undef = 1'b0;
          pre_ok = 1'b1;
          cls = s[0][`DEC_B_SEL] ? CL_DEC : CL_INC;
        end else if (s[0][`DEC_F_HI] == `DEC_NIB_PAIR &&
                     s[0][`DEC_B_HIPAIR]) begin
          undef = 1'b0;
          reg_a = {1'b1, s[0][`DEC_F_PP]};
          cls = s[0][`DEC_B_SEL] ? CL_DEC_WORD : CL_INC_WORD;
        end
      end
    endcase
    // A prefix adds one byte and moves short-direct access to the other area
    if (pre) begin
      hdr = hdr + `DEC_LEN1;
      len = len + `DEC_LEN1;
      undef = undef || !pre_ok;
      if (space == SP_SHORT_B) begin
        space = SP_SHORT_A;
      end
    end
  end

  // Finish once enough bytes identify the form and, if legal, fill it
  assign complete = bus.take && n >= hdr && (undef || n >= len);

  ////////////////////////////////////////////////////////////////////////////
  // Handshake sequencer: one idle cycle after each opcode to present it
  always_comb begin
    case (state_r)
      ST_FILL: state_nxt = complete ? ST_DONE : ST_FILL;
      ST_DONE: state_nxt = ST_FILL;
      default: state_nxt = ST_FILL;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_FILL;
      byte_ready <= 1'b1;
      dec_done <= 1'b0;
    end else begin
      state_r <= state_nxt;
      byte_ready <= (state_nxt == ST_FILL);
      dec_done <= complete;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result fields hold until the next opcode completes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dec_undef <= 1'b0;
      dec_class <= CL_NONE;
      dec_len <= 3'h0;
      dec_dir <= 1'b0;
      dec_reg_a <= 3'h0;
      dec_reg_b <= 3'h0;
      dec_count <= 3'h0;
      dec_bit_num <= 3'h0;
      dec_bit_op <= 4'h0;
      dec_member <= 1'b0;
      dec_space <= SP_NONE;
      dec_offset <= 8'h00;
      dec_imm <= 24'h000000;
    end else if (complete) begin
      dec_undef <= undef;
      dec_class <= undef ? CL_NONE : cls;
      dec_len <= n;
      dec_dir <= dir;
      dec_reg_a <= reg_a;
      dec_reg_b <= reg_b;
      dec_count <= cnt_f;
      dec_bit_num <= bit_num;
      dec_bit_op <= bit_op;
      dec_member <= member;
      dec_space <= space;
      dec_offset <= off;
      dec_imm <= imm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_ADD_RR: assert property (
    byte_valid && byte_ready && bus.cnt == 3'h1 &&
    bus.view[0] == `DEC_OP_ADD_RR && (byte_data & 8'h99) == 8'h99
    |=> dec_done && dec_class == CL_ADD_TRIPLE && dec_len == 3'h2)
    else $error("register triple add misdecoded");
  AST_SIGN_EXT: assert property (
    byte_valid && byte_ready && bus.cnt == 3'h0 && byte_data == 8'h04
    |=> dec_done && dec_class == CL_SIGN_EXT && dec_len == 3'h1)
    else $error("sign extension misdecoded");
  AST_PAIR_HI: assert property (
    byte_valid && byte_ready && bus.cnt == 3'h0 && byte_data[7:4] == 4'h4 &&
    byte_data[2] |=> dec_reg_a == {1'b1, $past(byte_data[1:0])} &&
    dec_class == ($past(byte_data[3]) ? CL_DEC_WORD : CL_INC_WORD))
    else $error("high pair increment misdecoded");
  AST_SHIFT: assert property (
    byte_valid && byte_ready && bus.cnt == 3'h1 &&
    bus.view[0] == `DEC_OP_SHIFT_L
    |=> dec_done && dec_dir && dec_count == $past(byte_data[5:3]) &&
    dec_reg_a == $past(byte_data[2:0]))
    else $error("shift fields wrong");
  AST_SUM_ABS: assert property (
    byte_valid && byte_ready && bus.cnt == 3'h3 && bus.view[0] == 8'h09 &&
    bus.view[1] == 8'h64 && bus.view[2] == 8'h41 && byte_data == 8'h46
    |=> dec_class == CL_SUM_ABS && !dec_undef && dec_len == 3'h4)
    else $error("correlation sequence misdecoded");
  AST_PREFIX_WAIT: assert property (
    byte_valid && byte_ready && bus.cnt == 3'h0 && byte_data == `DEC_OP_PREFIX
    |=> !dec_done && bus.cnt == 3'h1)
    else $error("prefix completed too early");
  AST_ABS_LEN: assert property (
    dec_done && !dec_undef && dec_space == SP_ABS
    |-> dec_len == (dec_member ? 3'h6 : 3'h5))
    else $error("absolute bit form length wrong");
  AST_UNDEF: assert property (
    byte_valid && byte_ready && bus.cnt == 3'h0 && byte_data == 8'hff
    |=> dec_done && dec_undef && dec_len == 3'h1)
    else $error("unknown byte not flagged");
  AST_HOLD_OFF: assert property (
    dec_done |-> !byte_ready ##1 byte_ready && !dec_done)
    else $error("ready not withdrawn for one cycle");
  AST_BIT_OP: assert property (
    dec_done && !dec_undef && dec_class == CL_BIT |-> dec_bit_op <= 4'h3)
    else $error("bit operation out of range");

  COV_IMM24: cover property (dec_done && dec_len == 3'h5 &&
    dec_class == CL_ADD_TRIPLE);
  COV_PREFIXED: cover property (dec_done && dec_space == SP_SHORT_A);
  COV_ABS24: cover property (dec_done && dec_space == SP_ABS && dec_member);
  COV_BACK2BACK: cover property (dec_done ##2 dec_done);
endmodule

// file: dec_fetch_model.sv
// Fetch stage model that offers opcode bytes to the decoder in order
module dec_fetch_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic byte_ready,
  input wire logic slow,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic idle
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] q [$];
  logic taken;
  logic gap;

  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
    idle = 1'b1;
    taken = 1'b0;
    gap = 1'b0;
  end

  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Handshake seen on the rising edge; the accepted byte leaves at once so
  // idle is settled before the bench looks at it on the falling edge
  always @(posedge clk) begin
    taken = byte_valid && byte_ready && !sys_rst;
    if (taken) begin
      void'(q.pop_front());
    end
    idle = (q.size() == 0);
  end

  // Offer is held until taken; slow mode idles one cycle after each byte
  always @(negedge clk) begin
    gap = taken && slow;
    byte_valid = (q.size() > 0) && !gap && !sys_rst;
    // Idle data toggles so a stale byte can never look valid
    byte_data = byte_valid ? q[0] : ~byte_data;
  end
endmodule

// file: opcode_decoder_arith_shift_bit_test.sv
// Self-checking bench for the opcode decoder
module opcode_decoder_arith_shift_bit_test import dec_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic slow = 1'b0;
  logic byte_valid, byte_ready, dec_done, dec_undef, dec_dir, dec_member;
  logic idle;
  logic [7:0] byte_data, dec_offset;
  logic [2:0] dec_len, dec_reg_a, dec_reg_b, dec_count, dec_bit_num;
  logic [3:0] dec_bit_op;
  logic [23:0] dec_imm;
  dec_class_e dec_class;
  dec_space_e dec_space;
  int n_mismatch = 0;
  int num_checks = 0;

  // Clock of 50 ns period
  always #25 clk = ~clk;

  dec_top dut (.clk, .sys_rst, .byte_valid, .byte_data, .byte_ready,
    .dec_done, .dec_undef, .dec_class, .dec_len, .dec_dir, .dec_reg_a,
    .dec_reg_b, .dec_count, .dec_bit_num, .dec_bit_op, .dec_member,
    .dec_space, .dec_offset, .dec_imm);
  dec_fetch_model fetch (.clk, .sys_rst, .byte_ready, .slow, .byte_valid,
    .byte_data, .idle);

  ////////////////////////////////////////////////////////////////////////////
  // Comparison and reporting
  task automatic chk_val(input string nm, input logic [23:0] e,
    input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_class(input dec_class_e e);
    num_checks++;
    if (dec_class !== e) begin
      n_mismatch++;
      $display("MISMATCH dec_class expected %0d seen %0d", e, dec_class);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Sends n bytes, first byte highest; the idle check proves exact length
  task automatic issue(input int n, input logic [47:0] s,
    input dec_class_e c, input logic [2:0] len);
    int k;
    for (int i = 0; i < n; i++)
      fetch.push(s[8*(n-1-i) +: 8]);
    k = 0;
    while (dec_done !== 1'b1 && k < 60) begin
      @(negedge clk);
      k++;
    end
    chk_val("dec_done", 24'h1, 24'(dec_done));
    chk_class(c);
    chk_val("dec_len", 24'(len), 24'(dec_len));
    chk_val("dec_undef", 24'(c == CL_NONE), 24'(dec_undef));
    chk_val("byte_ready", 24'h0, 24'(byte_ready));
    chk_val("fetch_idle", 24'h1, 24'(idle));
    @(negedge clk);
    chk_val("done_pulse", 24'h0, 24'(dec_done));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_triple();
    issue(2, 48'h88db, CL_ADD_TRIPLE, 3'h2);
    chk_val("reg_a", 24'h2, 24'(dec_reg_a));
    chk_val("reg_b", 24'h1, 24'(dec_reg_b));
    issue(2, 48'h8a99, CL_SUB_TRIPLE, 3'h2);
    chk_val("reg_b", 24'h0, 24'(dec_reg_b));
    issue(5, 48'h78fb112233, CL_ADD_TRIPLE, 3'h5);
    chk_val("imm", 24'h332211, dec_imm);
    chk_val("reg_a", 24'h3, 24'(dec_reg_a));
    issue(5, 48'h7a9b445566, CL_SUB_TRIPLE, 3'h5);
    chk_val("imm", 24'h665544, dec_imm);
    issue(3, 48'h78f85a, CL_ADD_TRIPLE, 3'h3);
    chk_val("space", 24'(SP_SHORT_B), 24'(dec_space));
    chk_val("offset", 24'h5a, 24'(dec_offset));
    issue(3, 48'h7af9a5, CL_SUB_TRIPLE, 3'h3);
    chk_val("space", 24'(SP_SHORT_A), 24'(dec_space));
    chk_val("offset", 24'ha5, 24'(dec_offset));
  endtask

  task automatic t_muldiv();
    dec_class_e c[5] = '{CL_MUL_UB, CL_MUL_UW, CL_MUL_SW, CL_DIV_UW,
      CL_DIV_UX};
    logic [3:0] nb[5] = '{4'h0, 4'h2, 4'h3, 4'h1, 4'he};
    for (int i = 0; i < 5; i++) begin
      issue(2, {8'h05, nb[i], 1'b1, 3'(i)}, c[i], 3'h2);
      chk_val("reg_a", 24'(i), 24'(dec_reg_a));
    end
    issue(3, 48'h3c050d, CL_MUL_UB, 3'h3);
    chk_val("reg_a", 24'h5, 24'(dec_reg_a));
    issue(3, 48'h3c051a, CL_DIV_UW, 3'h3);
  endtask

  task automatic t_special();
    issue(3, 48'h078577, CL_MAC, 3'h3);
    chk_val("imm", 24'h000077, dec_imm);
    issue(3, 48'h0795c4, CL_MAC_SAT, 3'h3);
    chk_val("imm", 24'h0000c4, dec_imm);
    issue(4, 48'h09644146, CL_SUM_ABS, 3'h4);
    issue(4, 48'h09644147, CL_NONE, 3'h4);
    issue(1, 48'hff, CL_NONE, 3'h1);
  endtask

  task automatic t_incdec();
    issue(1, 48'hc3, CL_INC, 3'h1);
    chk_val("reg_a", 24'h3, 24'(dec_reg_a));
    issue(1, 48'hcf, CL_DEC, 3'h1);
    chk_val("reg_a", 24'h7, 24'(dec_reg_a));
    issue(2, 48'h3cc2, CL_INC, 3'h2);
    issue(2, 48'h3edd, CL_INC_TRIPLE, 3'h2);
    chk_val("reg_a", 24'h2, 24'(dec_reg_a));
    issue(2, 48'h3ebf, CL_DEC_TRIPLE, 3'h2);
    chk_val("reg_a", 24'h1, 24'(dec_reg_a));
    issue(2, 48'h2640, CL_INC, 3'h2);
    chk_val("offset", 24'h40, 24'(dec_offset));
    issue(3, 48'h3c2741, CL_DEC, 3'h3);
    chk_val("space", 24'(SP_SHORT_A), 24'(dec_space));
    chk_val("offset", 24'h41, 24'(dec_offset));
  endtask

  task automatic t_word();
    issue(1, 48'h45, CL_INC_WORD, 3'h1);
    chk_val("reg_a", 24'h5, 24'(dec_reg_a));
    issue(1, 48'h4e, CL_DEC_WORD, 3'h1);
    chk_val("reg_a", 24'h6, 24'(dec_reg_a));
    issue(2, 48'h3e6d, CL_INC_WORD, 3'h2);
    chk_val("reg_a", 24'h3, 24'(dec_reg_a));
    issue(2, 48'h3e0f, CL_DEC_WORD, 3'h2);
    issue(3, 48'h07e812, CL_INC_WORD, 3'h3);
    chk_val("offset", 24'h12, 24'(dec_offset));
    issue(4, 48'h3c07e934, CL_DEC_WORD, 3'h4);
    chk_val("space", 24'(SP_SHORT_A), 24'(dec_space));
    chk_val("offset", 24'h34, 24'(dec_offset));
    issue(2, 48'h05fe, CL_FIX_ADD, 3'h2);
    issue(2, 48'h05ff, CL_FIX_SUB, 3'h2);
    issue(1, 48'h04, CL_SIGN_EXT, 3'h1);
    issue(2, 48'h3c04, CL_NONE, 3'h2);
  endtask

  // Run with fetch stalls between bytes
  task automatic t_shift();
    dec_class_e c[4] = '{CL_ROT_CARRY, CL_ROT, CL_SHIFT, CL_SHIFT_WORD};
    slow = 1'b1;
    for (int v = 0; v < 8; v++) begin
      issue(2, {7'h18, 1'(v / 4), 2'(v), 3'h5, 3'h2}, c[v%4], 3'h2);
      chk_val("dir", 24'(v / 4), 24'(dec_dir));
      chk_val("count", 24'h5, 24'(dec_count));
      chk_val("reg_a", 24'h2, 24'(dec_reg_a));
    end
    issue(3, 48'h3c316a, CL_ROT, 3'h3);
    issue(2, 48'h058b, CL_NIB_ROR, 3'h2);
    chk_val("reg_a", 24'h3, 24'(dec_reg_a));
    issue(2, 48'h059e, CL_NIB_ROL, 3'h2);
    chk_val("reg_a", 24'h6, 24'(dec_reg_a));
    slow = 1'b0;
  endtask

  task automatic t_bit();
    issue(3, 48'h08235a, CL_BIT, 3'h3);
    chk_val("space", 24'(SP_SHORT_B), 24'(dec_space));
    chk_val("bitop", 24'h2, 24'(dec_bit_op));
    chk_val("bitnum", 24'h3, 24'(dec_bit_num));
    issue(4, 48'h3c081566, CL_BIT, 3'h4);
    chk_val("space", 24'(SP_SHORT_A), 24'(dec_space));
    chk_val("offset", 24'h66, 24'(dec_offset));
    issue(2, 48'h030e, CL_BIT, 3'h2);
    chk_val("space", 24'(SP_ACC), 24'(dec_space));
    chk_val("member", 24'h1, 24'(dec_member));
    issue(2, 48'h0237, CL_BIT, 3'h2);
    chk_val("space", 24'(SP_PSW), 24'(dec_space));
    issue(2, 48'h3d01, CL_BIT, 3'h2);
    chk_val("space", 24'(SP_IND), 24'(dec_space));
    issue(5, 48'h09d0003412, CL_BIT, 3'h5);
    chk_val("imm", 24'h001234, dec_imm);
    issue(6, 48'h09d019ab3412, CL_BIT, 3'h6);
    chk_val("space", 24'(SP_ABS), 24'(dec_space));
    chk_val("imm", 24'hab1234, dec_imm);
    chk_val("member", 24'h1, 24'(dec_member));
    issue(2, 48'h0347, CL_NONE, 3'h2);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    chk_val("rst_ready", 24'h1, 24'(byte_ready));
    chk_val("rst_done", 24'h0, 24'(dec_done));
    chk_class(CL_NONE);
    sys_rst = 1'b0;
    @(negedge clk);
    t_triple();
    t_muldiv();
    t_special();
    t_incdec();
    t_word();
    t_shift();
    t_bit();
    complete_run();
  end

  // Watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    #(3000 * 50);
    n_mismatch++;
    complete_run();
  end
endmodule
